// ===== hdl/windowed_watchdog_timer.sv
// Windowed watchdog timer with its AXI4-Lite register slave
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic DEVICE_RESET,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] WATCHDOG_MODE_CFG,
  input wire logic [2:0] CFG_CLOCK_SELECT,
  input wire logic [4:0] CFG_PERIOD_SELECT,
  input wire logic [2:0] CFG_WINDOW_SELECT,
  input wire logic LOW_FREQ_INTERNAL_OSC,
  input wire logic MID_FREQ_INTERNAL_OSC,
  input wire logic SLEEP,
  input wire logic OSC_STARTUP_TIMER,
  input wire logic OSC_FAIL,
  input wire logic WATCHDOG_CLEAR_INSTR,
  output logic SYSTEM_RESET,
  output logic WAKE,
  output logic WINDOW_VIOLATION_FLAG_N,
  output logic TIMEOUT_RESET_FLAG_N,
  output logic TIMEOUT_STATUS_N,
  output logic POWERDOWN_STATUS_N
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] lf_sync_reg;
  logic [1:0] mf_sync_reg;
  logic lf_last_reg;
  logic mf_last_reg;
  logic [12:0] cfg_meta_reg;
  logic [12:0] cfg_sync_reg;
  logic [1:0] mode;
  logic [2:0] cfg_clock;
  logic [4:0] cfg_period;
  logic [2:0] cfg_window;

  always_ff @(posedge CLK) begin
    if (RST) begin
      lf_sync_reg <= 2'h0;
      mf_sync_reg <= 2'h0;
      lf_last_reg <= 1'b0;
      mf_last_reg <= 1'b0;
    end else begin
      lf_sync_reg <= {lf_sync_reg[0], LOW_FREQ_INTERNAL_OSC};
      mf_sync_reg <= {mf_sync_reg[0], MID_FREQ_INTERNAL_OSC};
      lf_last_reg <= lf_sync_reg[1];
      mf_last_reg <= mf_sync_reg[1];
    end
  end

  // Straps are static but cross in from pins, so they are synchronised too
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_meta_reg <= 13'h0000;
      cfg_sync_reg <= 13'h0000;
    end else begin
      cfg_meta_reg <= {WATCHDOG_MODE_CFG, CFG_CLOCK_SELECT, CFG_PERIOD_SELECT, CFG_WINDOW_SELECT};
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  assign mode = cfg_sync_reg[12:11];
  assign cfg_clock = cfg_sync_reg[10:8];
  assign cfg_period = cfg_sync_reg[7:3];
  assign cfg_window = cfg_sync_reg[2:0];

  // ----------------------------------------------------------------
  // Register bus: write path
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane;
  logic wr_mapped;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_flags;

  assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_held_reg && !bvalid_reg;
  assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_go = (aw_held_reg || aw_take) && (w_held_reg || w_take);
  assign wr_addr = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR;
  assign wr_data = w_held_reg ? w_data_reg : S_AXI_WDATA[7:0];
  assign wr_lane = w_held_reg ? w_lane_reg : S_AXI_WSTRB[0];
  assign wr_mapped = (wr_addr == ADDR_CONTROL_ZERO) || (wr_addr == ADDR_CLOCK_AND_WINDOW) ||
                     (wr_addr == ADDR_PRESCALE_READBACK) || (wr_addr == ADDR_COUNT_STATE) ||
                     (wr_addr == ADDR_RESET_FLAGS);
  assign wr_ctrl0 = wr_go && wr_lane && (wr_addr == ADDR_CONTROL_ZERO);
  assign wr_ctrl1 = wr_go && wr_lane && (wr_addr == ADDR_CLOCK_AND_WINDOW);
  assign wr_flags = wr_go && wr_lane && (wr_addr == ADDR_RESET_FLAGS);

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[7:0];
        w_lane_reg <= S_AXI_WSTRB[0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // ----------------------------------------------------------------
  // Control fields and effective settings
  // ----------------------------------------------------------------
  logic soft_enable_reg;
  logic [4:0] period_reg;
  logic [2:0] clock_sel_reg;
  logic [2:0] window_reg;
  logic [4:0] period_field;
  logic [2:0] clock_field;
  logic [2:0] window_field;
  logic enabled;
  logic sleep_prev_reg;

  // Any device reset restores the two-second default
  always_ff @(posedge CLK) begin
    if (RST || DEVICE_RESET) begin
      soft_enable_reg <= 1'b0;
      period_reg <= PERIOD_RESET;
      clock_sel_reg <= CLOCK_SEL_RESET;
      window_reg <= WINDOW_RESET;
    end else begin
      if (wr_ctrl0) begin
        soft_enable_reg <= wr_data[SOFT_ENABLE_BIT];
        if (cfg_period == PERIOD_RUNTIME_SEL) begin
          period_reg <= wr_data[PERIOD_LSB +: 5];
        end
      end
      if (wr_ctrl1) begin
        if (cfg_clock == FIELD_RUNTIME_SEL) begin
          clock_sel_reg <= wr_data[CLOCK_SEL_LSB +: 3];
        end
        if (cfg_window == FIELD_RUNTIME_SEL) begin
          window_reg <= wr_data[WINDOW_LSB +: 3];
        end
      end
    end
  end

  // Fixed fields read back the strap value
  assign period_field = (cfg_period == PERIOD_RUNTIME_SEL) ? period_reg : cfg_period;
  assign clock_field = (cfg_clock == FIELD_RUNTIME_SEL) ? clock_sel_reg : cfg_clock;
  assign window_field = (cfg_window == FIELD_RUNTIME_SEL) ? window_reg : cfg_window;

  always_comb begin
    case (mode)
      MODE_ALWAYS_ON: enabled = 1'b1;
      MODE_OFF_IN_SLEEP: enabled = !SLEEP;
      MODE_SOFTWARE: enabled = soft_enable_reg;
      default: enabled = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Count core and clear logic
  // ----------------------------------------------------------------
  wdt_count_if cnt ();
  logic windowed;
  logic window_open;
  logic clear_req;
  logic violation;
  logic valid_clear;
  logic sleep_enter;
  logic sleep_exit;
  logic timeout;
  logic armed_reg;
  logic rd_ctrl0;

  wdt_count_core u_count (
    .clk(CLK),
    .rst(RST),
    .cnt(cnt.core)
  );

  // Reserved clock codes keep the low-frequency base so protection stays on
  assign cnt.tick = (clock_field == CLOCK_SEL_MID_FREQ) ? (mf_sync_reg[1] && !mf_last_reg)
                                                         : (lf_sync_reg[1] && !lf_last_reg);
  assign cnt.period = period_clip(period_field);

  assign windowed = window_field != WINDOW_FULL;
  assign window_open = !windowed || (cnt.count >= window_threshold(window_field));
  assign clear_req = WATCHDOG_CLEAR_INSTR && enabled;
  assign violation = clear_req && windowed && (!armed_reg || !window_open);
  assign valid_clear = clear_req && !violation;
  assign sleep_enter = SLEEP && !sleep_prev_reg;
  assign sleep_exit = !SLEEP && sleep_prev_reg;

  // Divider changes of the system oscillator are not an input: count unaffected
  assign cnt.clear = DEVICE_RESET || valid_clear || violation || sleep_enter || sleep_exit ||
                     !enabled || OSC_STARTUP_TIMER || OSC_FAIL ||
                     wr_ctrl0 || wr_ctrl1;
  assign timeout = cnt.overflow && enabled;

  always_ff @(posedge CLK) begin
    if (RST) begin
      sleep_prev_reg <= 1'b0;
    end else begin
      sleep_prev_reg <= SLEEP;
    end
  end

  // Arming read wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      armed_reg <= 1'b0;
    end else if (rd_ctrl0) begin
      armed_reg <= 1'b1;
    end else if (cnt.clear || clear_req) begin
      armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset, wake and flag outputs
  // ----------------------------------------------------------------
  logic sys_reset_reg;
  logic wake_reg;
  logic violation_n_reg;
  logic timeout_reset_n_reg;
  logic timeout_status_n_reg;
  logic powerdown_status_n_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      sys_reset_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      sys_reset_reg <= violation || (timeout && !SLEEP);
      wake_reg <= timeout && SLEEP;
    end
  end

  // Hardware clears win over a software write in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      violation_n_reg <= 1'b1;
    end else if (violation) begin
      violation_n_reg <= 1'b0;
    end else if (wr_flags) begin
      violation_n_reg <= wr_data[FLAG_WINDOW_VIOLATION_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      timeout_reset_n_reg <= 1'b1;
    end else if (timeout) begin
      timeout_reset_n_reg <= 1'b0;
    end else if (wr_flags) begin
      timeout_reset_n_reg <= wr_data[FLAG_TIMEOUT_RESET_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      timeout_status_n_reg <= 1'b1;
      powerdown_status_n_reg <= 1'b1;
    end else begin
      if (timeout) begin
        timeout_status_n_reg <= 1'b0;
      end else if (wr_flags) begin
        timeout_status_n_reg <= wr_data[FLAG_TIMEOUT_STATUS_BIT];
      end
      if (timeout && SLEEP) begin
        powerdown_status_n_reg <= 1'b0;
      end else if (wr_flags) begin
        powerdown_status_n_reg <= wr_data[FLAG_POWERDOWN_STATUS_BIT];
      end
    end
  end

  assign SYSTEM_RESET = sys_reset_reg;
  assign WAKE = wake_reg;
  assign WINDOW_VIOLATION_FLAG_N = violation_n_reg;
  assign TIMEOUT_RESET_FLAG_N = timeout_reset_n_reg;
  assign TIMEOUT_STATUS_N = timeout_status_n_reg;
  assign POWERDOWN_STATUS_N = powerdown_status_n_reg;

  // ----------------------------------------------------------------
  // Register bus: read path
  // ----------------------------------------------------------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_take;
  logic [31:0] rd_word;
  logic rd_mapped;

  assign S_AXI_ARREADY = !rvalid_reg;
  assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_ctrl0 = ar_take && (S_AXI_ARADDR == ADDR_CONTROL_ZERO);

  always_comb begin
    rd_word = 32'h00000000;
    rd_mapped = 1'b1;
    case (S_AXI_ARADDR)
      ADDR_CONTROL_ZERO: begin
        rd_word[PERIOD_LSB +: 5] = period_field;
        rd_word[SOFT_ENABLE_BIT] = soft_enable_reg;
      end
      ADDR_CLOCK_AND_WINDOW: begin
        rd_word[CLOCK_SEL_LSB +: 3] = clock_field;
        rd_word[WINDOW_LSB +: 3] = window_field;
      end
      ADDR_PRESCALE_READBACK: begin
        rd_word[15:0] = cnt.prescale[17:2];
      end
      ADDR_COUNT_STATE: begin
        rd_word[COUNT_LSB +: 5] = cnt.count;
        rd_word[ARMED_BIT] = armed_reg;
        rd_word[PRESCALE_LOW_LSB +: 2] = cnt.prescale[1:0];
      end
      ADDR_RESET_FLAGS: begin
        rd_word[FLAG_WINDOW_VIOLATION_BIT] = violation_n_reg;
        rd_word[FLAG_TIMEOUT_RESET_BIT] = timeout_reset_n_reg;
        rd_word[FLAG_TIMEOUT_STATUS_BIT] = timeout_status_n_reg;
        rd_word[FLAG_POWERDOWN_STATUS_BIT] = powerdown_status_n_reg;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
endmodule // windowed_watchdog_timer

// ===== hdl/wdt_pkg.sv
// Shared constants, register map and helper functions of the windowed watchdog
package wdt_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [11:0] IDX_CONTROL_ZERO = 12'hED2;
  localparam logic [11:0] IDX_CLOCK_AND_WINDOW = 12'hED3;
  localparam logic [11:0] IDX_PRESCALE_READBACK = 12'hED4;
  localparam logic [11:0] IDX_COUNT_STATE = 12'hED6;
  localparam logic [11:0] IDX_RESET_FLAGS = 12'hED8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_ZERO = {2'h0, IDX_CONTROL_ZERO, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_AND_WINDOW = {2'h0, IDX_CLOCK_AND_WINDOW, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRESCALE_READBACK = {2'h0, IDX_PRESCALE_READBACK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_COUNT_STATE = {2'h0, IDX_COUNT_STATE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RESET_FLAGS = {2'h0, IDX_RESET_FLAGS, 2'h0};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SOFT_ENABLE_BIT = 0;
  localparam int PERIOD_LSB = 1;
  localparam int WINDOW_LSB = 0;
  localparam int CLOCK_SEL_LSB = 4;
  localparam int PRESCALE_LOW_LSB = 0;
  localparam int ARMED_BIT = 2;
  localparam int COUNT_LSB = 3;
  localparam int FLAG_TIMEOUT_RESET_BIT = 0;
  localparam int FLAG_WINDOW_VIOLATION_BIT = 1;
  localparam int FLAG_TIMEOUT_STATUS_BIT = 2;
  localparam int FLAG_POWERDOWN_STATUS_BIT = 3;

  // ----------------------------------------------------------------
  // Widths, codes and reset values
  // ----------------------------------------------------------------
  localparam int PRESCALE_W = 18;
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 5'h1F;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
  localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
  localparam logic [4:0] PERIOD_RUNTIME_SEL = 5'h1F;
  localparam logic [4:0] PERIOD_RESET = 5'h0B;
  localparam logic [4:0] PERIOD_MAX = 5'h12;
  localparam logic [4:0] PERIOD_MIN = 5'h00;
  localparam logic [2:0] FIELD_RUNTIME_SEL = 3'h7;
  localparam logic [2:0] CLOCK_SEL_RESET = 3'h0;
  localparam logic [2:0] CLOCK_SEL_LOW_FREQ = 3'h0;
  localparam logic [2:0] CLOCK_SEL_MID_FREQ = 3'h1;
  localparam logic [2:0] WINDOW_RESET = 3'h7;
  localparam logic [2:0] WINDOW_FULL = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reserved period codes fall back to the shortest interval
  function automatic logic [4:0] period_clip(input logic [4:0] sel);
    period_clip = (sel > PERIOD_MAX) ? PERIOD_MIN : sel;
  endfunction

  // Prescale bits that must all be one for a counter step
  function automatic logic [PRESCALE_W-1:0] tap_mask(input logic [4:0] sel);
    tap_mask = ~({PRESCALE_W{1'b1}} << sel);
  endfunction

  // Counter value at which the window opens: (7 - w) eighths of 32
  function automatic logic [COUNT_W-1:0] window_threshold(input logic [2:0] w);
    window_threshold = {~w, 2'h0};
  endfunction
endpackage

// ===== hdl/wdt_count_if.sv
// Bundle between the watchdog control logic and its count core
interface wdt_count_if;
  logic tick;
  logic clear;
  logic [4:0] period;
  logic [17:0] prescale;
  logic [4:0] count;
  logic overflow;
  modport core(input tick, input clear, input period, output prescale, output count, output overflow);
  modport ctrl(output tick, output clear, output period, input prescale, input count, input overflow);
endinterface

// ===== hdl/wdt_count_core.sv
// Prescale counter and five-bit watchdog counter
module wdt_count_core
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  wdt_count_if.core cnt
);
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [COUNT_W-1:0] count_reg;
  logic tap;

  assign tap = (prescale_reg & tap_mask(cnt.period)) == tap_mask(cnt.period);
  // Clear has priority so a cleared count never reports overflow
  assign cnt.overflow = cnt.tick && tap && (count_reg == COUNT_MAX) && !cnt.clear;
  assign cnt.prescale = prescale_reg;
  assign cnt.count = count_reg;

  always_ff @(posedge clk) begin
    if (rst || cnt.clear) begin
      prescale_reg <= '0;
    end else if (cnt.tick) begin
      prescale_reg <= prescale_reg + 18'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cnt.clear) begin
      count_reg <= '0;
    end else if (cnt.tick && tap) begin
      count_reg <= count_reg + 5'h01;
    end
  end
endmodule // wdt_count_core

// ===== tb/windowed_watchdog_timer_props.sv
// Port-level property checker of the windowed watchdog timer
module windowed_watchdog_timer_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] WATCHDOG_MODE_CFG,
  input wire logic SLEEP,
  input wire logic OSC_STARTUP_TIMER,
  input wire logic OSC_FAIL,
  input wire logic WATCHDOG_CLEAR_INSTR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_WVALID,
  input wire logic SYSTEM_RESET,
  input wire logic WAKE,
  input wire logic WINDOW_VIOLATION_FLAG_N,
  input wire logic TIMEOUT_RESET_FLAG_N,
  input wire logic POWERDOWN_STATUS_N
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_reset_one_cycle: assert property (SYSTEM_RESET |=> !SYSTEM_RESET)
    else $error("system reset wider than one cycle");
  a_reset_cause: assert property (SYSTEM_RESET |-> !WINDOW_VIOLATION_FLAG_N || !TIMEOUT_RESET_FLAG_N)
    else $error("system reset without a flagged cause");
  a_violation_flag: assert property ($fell(WINDOW_VIOLATION_FLAG_N) |-> SYSTEM_RESET)
    else $error("violation flag dropped without reset");
  a_timeout_flag: assert property ($fell(TIMEOUT_RESET_FLAG_N) |-> SYSTEM_RESET || WAKE)
    else $error("timeout flag dropped without time-out");
  a_flag_hold: assert property (!TIMEOUT_RESET_FLAG_N && !S_AXI_AWVALID && !S_AXI_WVALID |=> !TIMEOUT_RESET_FLAG_N)
    else $error("timeout flag rose without a write");
  a_wake_in_sleep: assert property (WAKE |-> $past(SLEEP) && !SYSTEM_RESET)
    else $error("wake pulse while awake");
  a_pd_on_wake: assert property ($fell(POWERDOWN_STATUS_N) |-> WAKE)
    else $error("powerdown status dropped without wake");
  a_mode_off_quiet: assert property ((WATCHDOG_MODE_CFG == 2'h0)[*5] |=> !SYSTEM_RESET && !WAKE)
    else $error("event while mode is off");
  a_sleep_off_quiet: assert property ((WATCHDOG_MODE_CFG == 2'h2 && SLEEP)[*5] |=> !SYSTEM_RESET && !WAKE)
    else $error("event in sleep with sleep-off mode");
  a_startup_hold: assert property ((OSC_STARTUP_TIMER && !WATCHDOG_CLEAR_INSTR)[*5] |=> !SYSTEM_RESET && !WAKE)
    else $error("time-out while start-up timer runs");
  a_fail_hold: assert property ((OSC_FAIL && !WATCHDOG_CLEAR_INSTR)[*5] |=> !SYSTEM_RESET && !WAKE)
    else $error("time-out while oscillator failed");
endmodule // windowed_watchdog_timer_props

bind windowed_watchdog_timer windowed_watchdog_timer_props u_windowed_watchdog_timer_props (.*);

// ===== tb/windowed_watchdog_timer_tb.sv
// Self-checking testbench of the windowed watchdog timer
module windowed_watchdog_timer_tb
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST, DEVICE_RESET, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, SLEEP, OSC_STARTUP_TIMER;
  logic OSC_FAIL, WATCHDOG_CLEAR_INSTR, SYSTEM_RESET, WAKE, WINDOW_VIOLATION_FLAG_N, TIMEOUT_RESET_FLAG_N;
  logic TIMEOUT_STATUS_N, POWERDOWN_STATUS_N, LOW_FREQ_INTERNAL_OSC, MID_FREQ_INTERNAL_OSC, mi_en;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, WATCHDOG_MODE_CFG, osc_cnt;
  logic [2:0] CFG_CLOCK_SELECT, CFG_WINDOW_SELECT;
  logic [4:0] CFG_PERIOD_SELECT;
  int failures, n_tests;

  windowed_watchdog_timer u_windowed_watchdog_timer (.*);

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // Oscillators at CLK/4: slow enough for the edge detector
  always @(posedge CLK) begin
    osc_cnt <= osc_cnt + 2'h1;
    LOW_FREQ_INTERNAL_OSC <= osc_cnt[1];
    MID_FREQ_INTERNAL_OSC <= osc_cnt[1] & mi_en;
  end

  // --------------------
  // Helpers
  // --------------------
  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk("bresp", 32'(RESP_OKAY), 32'(S_AXI_BRESP));
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] r = RESP_OKAY);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk("rresp", 32'(r), 32'(S_AXI_RRESP));
    chk("rdata", e, S_AXI_RDATA & m);
  endtask

  task automatic clr();
    @(posedge CLK);
    WATCHDOG_CLEAR_INSTR <= 1'b1;
    @(posedge CLK);
    WATCHDOG_CLEAR_INSTR <= 1'b0;
  endtask

  // Kind seen within hi cycles: 0 none, 1 system reset, 2 wake
  task automatic ev(input string nm, input int lo, input int hi, input int k);
    int t;
    int g;
    g = 0;
    for (t = 0; t < hi && g == 0; t++) begin
      @(posedge CLK);
      if (SYSTEM_RESET === 1'b1) g = 1;
      else if (WAKE === 1'b1) g = 2;
    end
    chk(nm, k, g);
    if (k != 0) chk({nm, "_late"}, 1, 32'(t >= lo));
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_regs();
    rd(ADDR_CONTROL_ZERO, 32'h16);
    rd(ADDR_CLOCK_AND_WINDOW, 32'h07);
    rd(ADDR_RESET_FLAGS, 32'h0F);
    rd(16'h0010, 32'h00, 32'hFFFFFFFF, RESP_SLVERR);
    wr(ADDR_CONTROL_ZERO, 8'h25);
    @(posedge CLK);
    DEVICE_RESET <= 1'b1;
    @(posedge CLK);
    DEVICE_RESET <= 1'b0;
    rd(ADDR_CONTROL_ZERO, 32'h16);
    rd(ADDR_COUNT_STATE, 32'h00);
    rd(ADDR_PRESCALE_READBACK, 32'h00);
  endtask

  task automatic t_periods();
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_CONTROL_ZERO, 8'((p << 1) | 1));
      ev("timeout", (128 << p) - 13, (128 << p) + 17, 1);
      chk("rst_flag", 0, 32'(TIMEOUT_RESET_FLAG_N));
      wr(ADDR_RESET_FLAGS, 8'h0F);
      chk("rst_flag", 1, 32'(TIMEOUT_RESET_FLAG_N));
    end
  endtask

  task automatic t_enable();
    wr(ADDR_CONTROL_ZERO, 8'h00);
    ev("soft_off", 0, 300, 0);
    WATCHDOG_MODE_CFG <= 2'h0;
    wr(ADDR_CONTROL_ZERO, 8'h01);
    ev("mode_off", 0, 300, 0);
    clr();
    ev("off_clear", 0, 4, 0);
    WATCHDOG_MODE_CFG <= 2'h1;
  endtask

  task automatic t_clksel();
    mi_en <= 1'b0;
    wr(ADDR_CLOCK_AND_WINDOW, 8'h17);
    wr(ADDR_CONTROL_ZERO, 8'h01);
    ev("mid_stopped", 0, 300, 0);
    mi_en <= 1'b1;
    wr(ADDR_CONTROL_ZERO, 8'h01);
    ev("mid_run", 115, 145, 1);
    wr(ADDR_CLOCK_AND_WINDOW, 8'h07);
  endtask

  // Clear lands near count 4*(7-w) minus or plus two
  task automatic t_window();
    for (int w = 0; w < 7; w++) begin
      wr(ADDR_CLOCK_AND_WINDOW, 8'(w));
      for (int o = 0; o < 2; o++) begin
        wr(ADDR_CONTROL_ZERO, 8'h01);
        repeat (16 * (7 - w) - 12 + 16 * o) @(posedge CLK);
        rd(ADDR_CONTROL_ZERO, 32'h01);
        clr();
        ev("window", 0, 3, 1 - o);
        chk("wv_flag", o, 32'(WINDOW_VIOLATION_FLAG_N));
        wr(ADDR_RESET_FLAGS, 8'h0F);
        chk("wv_flag", 1, 32'(WINDOW_VIOLATION_FLAG_N));
      end
    end
    wr(ADDR_CONTROL_ZERO, 8'h01);
    repeat (24) @(posedge CLK);
    clr();
    ev("unarmed", 0, 3, 1);
    wr(ADDR_CLOCK_AND_WINDOW, 8'h07);
  endtask

  task automatic t_sleep();
    WATCHDOG_MODE_CFG <= 2'h2;
    wr(ADDR_CONTROL_ZERO, 8'h01);
    SLEEP <= 1'b1;
    ev("sleep_off", 0, 300, 0);
    SLEEP <= 1'b0;
    ev("awake_on", 115, 145, 1);
    // Restore the status bits so the sleep time-out has to drop them itself
    wr(ADDR_RESET_FLAGS, 8'h0F);
    WATCHDOG_MODE_CFG <= 2'h3;
    SLEEP <= 1'b1;
    ev("sleep_wake", 115, 145, 2);
    chk("status", 0, 32'({TIMEOUT_STATUS_N, POWERDOWN_STATUS_N}));
    SLEEP <= 1'b0;
  endtask

  task automatic t_holds();
    wr(ADDR_CONTROL_ZERO, 8'h01);
    OSC_STARTUP_TIMER <= 1'b1;
    ev("startup", 0, 300, 0);
    rd(ADDR_COUNT_STATE, 32'h00, 32'hF8);
    OSC_STARTUP_TIMER <= 1'b0;
    OSC_FAIL <= 1'b1;
    ev("osc_fail", 0, 300, 0);
    OSC_FAIL <= 1'b0;
    ev("after_fail", 115, 145, 1);
    // Fixed period strap: the written period code must be ignored
    CFG_PERIOD_SELECT <= 5'h00;
    repeat (3) @(posedge CLK);
    wr(ADDR_CONTROL_ZERO, 8'h05);
    rd(ADDR_CONTROL_ZERO, 32'h01);
    ev("cfg_period", 115, 145, 1);
  endtask

  initial begin
    {RST, DEVICE_RESET, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 7'h40;
    {SLEEP, OSC_STARTUP_TIMER, OSC_FAIL, WATCHDOG_CLEAR_INSTR, mi_en} = 5'h01;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, osc_cnt} = 66'h0;
    {LOW_FREQ_INTERNAL_OSC, MID_FREQ_INTERNAL_OSC, S_AXI_WSTRB} = 6'h0F;
    {WATCHDOG_MODE_CFG, CFG_CLOCK_SELECT, CFG_PERIOD_SELECT, CFG_WINDOW_SELECT} = 13'h0FFF;
    failures = 0;
    n_tests = 0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    t_regs();
    t_periods();
    t_enable();
    t_clksel();
    t_window();
    t_sleep();
    t_holds();
    end_sim();
  end

  // Hang guard, several times the expected run length
  initial begin
    #1000000;
    failures++;
    end_sim();
  end
endmodule // windowed_watchdog_timer_tb
